/* File: hw/tct_pkg.sv */
`default_nettype none
package tct_pkg;
  localparam int          TCT_N            = 3;
  localparam int          TCT_W            = 32;
  localparam int          TCT_AW           = 8;
  // device map: per timer offsets relative to the timer base, the timer stride, then shared absolute addresses
  localparam logic [7:0]  OFF_RELOAD       = 8'h00;
  localparam logic [7:0]  OFF_COUNT        = 8'h04;
  localparam logic [7:0]  OFF_SETUP        = 8'h08;
  localparam logic [7:0]  OFF_ACK          = 8'h0c;
  localparam logic [7:0]  OFF_FLAG         = 8'h10;
  localparam logic [7:0]  TIMER_STRIDE     = 8'h14;
  localparam logic [7:0]  OFF_ALL_FLAGS    = 8'ha0;
  localparam logic [7:0]  OFF_ALL_ACK      = 8'ha4;
  localparam logic [7:0]  OFF_ALL_RAW      = 8'ha8;
  localparam int          SETUP_EN_BIT     = 0;
  localparam int          SETUP_MODE_BIT   = 1;
  localparam int          SETUP_MASK_BIT   = 2;
  localparam logic [31:0] RELOAD_RST       = 32'h0000_0000;
  localparam logic [2:0]  SETUP_RST        = 3'h0;
  // host command map
  localparam logic [7:0]  HOFF_TARGET      = 8'h00;
  localparam logic [7:0]  HOFF_DATA        = 8'h04;
  localparam logic [7:0]  HOFF_GO          = 8'h08;
  localparam logic [7:0]  HOFF_RESULT      = 8'h0c;
  localparam logic [7:0]  HOFF_STATUS      = 8'h10;
  localparam logic [7:0]  HOFF_CLK_GATE    = 8'h14;
  localparam int          GO_WRITE_BIT     = 0;
  localparam logic [2:0]  CLK_GATE_RST     = 3'h7;
  // timing
  localparam int          CLK_HZ           = 200_000_000;
  localparam int          TCLK_HZ          = 24_000_000;
  localparam int          TCLK_HALF_CYCLES = CLK_HZ / (2 * TCLK_HZ);
endpackage
`default_nettype wire

/* File: hw/tct_if.sv */
`default_nettype none
interface tct_if;
  logic [tct_pkg::TCT_AW-1:0] addr;
  logic [31:0]                wdata;
  logic                       wr;
  logic                       rd;
  logic [31:0]                rdata;
  logic [tct_pkg::TCT_N-1:0]  timer_en;
  logic [tct_pkg::TCT_N-1:0]  timer_clk;

  modport dev_mp (
    input  addr,
    input  wdata,
    input  wr,
    input  rd,
    output rdata,
    output timer_en,
    input  timer_clk
  );

  modport host_mp (
    output addr,
    output wdata,
    output wr,
    output rd,
    input  rdata,
    input  timer_en,
    output timer_clk
  );
endinterface
`default_nettype wire

/* File: hw/tct_channel.sv */
`default_nettype none
module tct_channel #(
  parameter int W = tct_pkg::TCT_W
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         enable,
  input  wire logic         user_mode,
  input  wire logic [W-1:0] load_value,
  input  wire logic         tick_pin,
  input  wire logic         clear,
  output logic      [W-1:0] count,
  output logic              raw_flag
);
  import tct_pkg::*;

  logic sync1;
  logic sync2;
  logic sync3;
  logic en_d;
  logic load_pend;
  logic tick;
  logic zero_event;

  // counting clock pin: two flops, then edge detect on the second; cleared while disabled
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
    end else if (!enable) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
    end else begin
      sync1 <= tick_pin;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  assign tick = sync2 & ~sync3;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      en_d <= 1'b0;
    end else begin
      en_d <= enable;
    end
  end

  // rising enable arms a load for the next counting edge
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      load_pend <= 1'b0;
    end else if (!enable) begin
      load_pend <= 1'b0;
    end else if (!en_d) begin
      load_pend <= 1'b1;
    end else if (tick) begin
      load_pend <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count <= '0;
    end else if (!enable) begin
      count <= '0;
    end else if (tick) begin
      if (load_pend) begin
        count <= load_value;
      end else if (count == '0) begin
        count <= user_mode ? load_value : '1;
      end else begin
        count <= count - W'(1);
      end
    end
  end

  assign zero_event = enable & tick & ~load_pend & (count == W'(1));

  // set wins over a clear in the same cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      raw_flag <= 1'b0;
    end else begin
      raw_flag <= (raw_flag & ~clear) | zero_event;
    end
  end
endmodule
`default_nettype wire

/* File: hw/tct_device.sv */
// Behaviour
// - three 32-bit timers with full register sets
// - count down, interrupt on reaching zero
// - setup bit 0 enables the timer
// - decrement on each rising counting clock edge
// - enable rise loads reload value next edge
// - disabling clears counter and counting-side state
// - disabled timer reads back zero count
// - user mode reloads the load value
// - free-running mode reloads all ones
// - setup bit 2 masks the interrupt output
// - load register is full 32-bit read/write
// - per-timer ack read returns zero, clears
// - shared ack read clears all three
// - combined status shows masked flags
// - combined raw status shows unmasked flags
// - enable bit drives the enable output
// - counting clock unrelated to bus clock
// - master disables, sets mode, loads, enables
// - master enables before ungating the clock
// - master disables before gating the clock
// - master uses full 32-bit accesses only
`default_nettype none
module tct_device #(
  parameter int N = tct_pkg::TCT_N,
  parameter int W = tct_pkg::TCT_W
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  tct_if.dev_mp             bus,
  output logic      [N-1:0] timer_irq
);
  import tct_pkg::*;

  logic [W-1:0] reload  [N];
  logic [2:0]   setup   [N];
  logic [W-1:0] count   [N];
  logic [N-1:0] raw;
  logic [N-1:0] masked;
  logic [N-1:0] enable;
  logic [N-1:0] user_mode;
  logic [N-1:0] mask;
  logic [N-1:0] clear;
  logic [31:0]  next_rdata;
  logic         all_ack_rd;
  logic [N-1:0] sel_reload;
  logic [N-1:0] sel_count;
  logic [N-1:0] sel_setup;
  logic [N-1:0] sel_ack;
  logic [N-1:0] sel_flag;
  logic [N-1:0] wr_reload;
  logic [N-1:0] wr_setup;
  logic         sel_all_flags;
  logic         sel_all_raw;
  logic [31:0]  timer_word [N];

  function automatic logic [7:0] base_of(input int n);
    base_of = 8'(n * TIMER_STRIDE);
  endfunction

  function automatic logic hit(input logic [7:0] a, input int n, input logic [7:0] off);
    hit = (a == 8'(base_of(n) + off));
  endfunction

  // one select line per register of every timer
  always_comb begin
    for (int n = 0; n < N; n++) begin
      sel_reload[n] = hit(bus.addr, n, OFF_RELOAD);
      sel_count[n]  = hit(bus.addr, n, OFF_COUNT);
      sel_setup[n]  = hit(bus.addr, n, OFF_SETUP);
      sel_ack[n]    = hit(bus.addr, n, OFF_ACK);
      sel_flag[n]   = hit(bus.addr, n, OFF_FLAG);
    end
  end

  assign sel_all_flags = (bus.addr == OFF_ALL_FLAGS);
  assign sel_all_raw   = (bus.addr == OFF_ALL_RAW);
  assign wr_reload     = sel_reload & {N{bus.wr}};
  assign wr_setup      = sel_setup & {N{bus.wr}};

  always_comb begin
    for (int n = 0; n < N; n++) begin
      enable[n]    = setup[n][SETUP_EN_BIT];
      user_mode[n] = setup[n][SETUP_MODE_BIT];
      mask[n]      = setup[n][SETUP_MASK_BIT];
    end
  end

  assign bus.timer_en = enable;

  // reload registers, whole word only
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int n = 0; n < N; n++) begin
        reload[n] <= RELOAD_RST;
      end
    end else begin
      for (int n = 0; n < N; n++) begin
        if (wr_reload[n]) begin
          reload[n] <= bus.wdata;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int n = 0; n < N; n++) begin
        setup[n] <= SETUP_RST;
      end
    end else begin
      for (int n = 0; n < N; n++) begin
        if (wr_setup[n]) begin
          setup[n] <= bus.wdata[2:0];
        end
      end
    end
  end

  // reads of an ack location clear flags as a side effect
  assign all_ack_rd = bus.rd && (bus.addr == OFF_ALL_ACK);

  always_comb begin
    for (int n = 0; n < N; n++) begin
      clear[n] = all_ack_rd || (bus.rd && sel_ack[n]);
    end
  end

  // flags are produced on the bus clock after the pin synchroniser
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_timer
      tct_channel #(
        .W (W)
      ) u_channel (
        .clk        (clk),
        .nrst       (nrst),
        .enable     (enable[g]),
        .user_mode  (user_mode[g]),
        .load_value (reload[g]),
        .tick_pin   (bus.timer_clk[g]),
        .clear      (clear[g]),
        .count      (count[g]),
        .raw_flag   (raw[g])
      );
    end
  endgenerate

  // the mask gates the outputs, the combined flags and the per-timer flag reads; raw status stays readable
  assign masked = raw & ~mask;

  // registered so the interrupt lines never carry decode glitches
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      timer_irq <= '0;
    end else begin
      timer_irq <= masked;
    end
  end

  // every timer offers one word, at most one of them selected
  always_comb begin
    for (int n = 0; n < N; n++) begin
      timer_word[n] = 32'h0000_0000;
      if (sel_reload[n]) begin
        timer_word[n] = 32'(reload[n]);
      end
      if (sel_count[n] && enable[n]) begin
        timer_word[n] = 32'(count[n]);
      end
      if (sel_setup[n]) begin
        timer_word[n] = 32'(setup[n]);
      end
      if (sel_flag[n]) begin
        timer_word[n] = 32'(masked[n]);
      end
    end
  end

  // shared status words, merged with the selected timer word
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (sel_all_flags) begin
      next_rdata = 32'(masked);
    end
    if (sel_all_raw) begin
      next_rdata = 32'(raw);
    end
    for (int n = 0; n < N; n++) begin
      next_rdata = next_rdata | timer_word[n];
    end
  end

  // ack locations and unmapped addresses read zero
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bus.rdata <= 32'h0000_0000;
    end else if (bus.rd) begin
      bus.rdata <= next_rdata;
    end else begin
      bus.rdata <= 32'h0000_0000;
    end
  end
endmodule
`default_nettype wire

/* File: hw/tct_host.sv */
`default_nettype none
module tct_host #(
  parameter int N          = tct_pkg::TCT_N,
  parameter int HALF_TICKS = tct_pkg::TCLK_HALF_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  tct_if.host_mp           bus,
  input  wire logic [7:0]  cmd_addr,
  input  wire logic [31:0] cmd_wdata,
  input  wire logic        cmd_wr,
  input  wire logic        cmd_rd,
  output logic      [31:0] cmd_rdata
);
  import tct_pkg::*;

  typedef enum logic [1:0] {
    TCT_IDLE,
    TCT_ISSUE,
    TCT_CAPTURE
  } tct_state_t;

  tct_state_t  state;
  logic        dir_write;
  logic [31:0] result;
  logic [N-1:0] gate;
  logic [7:0]  div;
  logic        level;
  logic        go;
  logic [31:0] next_cmd_rdata;

  assign go = cmd_wr && (cmd_addr == HOFF_GO) && (state == TCT_IDLE);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bus.addr  <= '0;
      bus.wdata <= 32'h0000_0000;
    end else if (cmd_wr && cmd_addr == HOFF_TARGET) begin
      bus.addr  <= cmd_wdata[7:0];
    end else if (cmd_wr && cmd_addr == HOFF_DATA) begin
      bus.wdata <= cmd_wdata;
    end
  end

  // one bus strobe per command, read data captured the cycle after
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state     <= TCT_IDLE;
      dir_write <= 1'b0;
      bus.wr    <= 1'b0;
      bus.rd    <= 1'b0;
    end else begin
      unique case (state)
        TCT_IDLE: begin
          if (go) begin
            state     <= TCT_ISSUE;
            dir_write <= cmd_wdata[GO_WRITE_BIT];
            bus.wr    <= cmd_wdata[GO_WRITE_BIT];
            bus.rd    <= ~cmd_wdata[GO_WRITE_BIT];
          end
        end
        TCT_ISSUE: begin
          state  <= TCT_CAPTURE;
          bus.wr <= 1'b0;
          bus.rd <= 1'b0;
        end
        TCT_CAPTURE: begin
          state <= TCT_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      result <= 32'h0000_0000;
    end else if (state == TCT_CAPTURE && !dir_write) begin
      result <= bus.rdata;
    end
  end

  // clock gating: software ungates only after enabling and gates after disabling
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gate <= N'(CLK_GATE_RST);
    end else if (cmd_wr && cmd_addr == HOFF_CLK_GATE) begin
      gate <= cmd_wdata[N-1:0];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div   <= '0;
      level <= 1'b0;
    end else if (div == 8'(HALF_TICKS - 1)) begin
      div   <= '0;
      level <= ~level;
    end else begin
      div   <= div + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bus.timer_clk <= '0;
    end else begin
      bus.timer_clk <= {N{level}} & ~gate;
    end
  end

  always_comb begin
    next_cmd_rdata = 32'h0000_0000;
    unique case (cmd_addr)
      HOFF_TARGET:   next_cmd_rdata = 32'(bus.addr);
      HOFF_DATA:     next_cmd_rdata = bus.wdata;
      HOFF_RESULT:   next_cmd_rdata = result;
      HOFF_STATUS:   next_cmd_rdata = {29'h0, bus.timer_en[0], 1'b0, state != TCT_IDLE} |
                                      (32'(bus.timer_en) << 2);
      HOFF_CLK_GATE: next_cmd_rdata = 32'(gate);
      default:       next_cmd_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cmd_rdata <= 32'h0000_0000;
    end else if (cmd_rd) begin
      cmd_rdata <= next_cmd_rdata;
    end else begin
      cmd_rdata <= 32'h0000_0000;
    end
  end
endmodule
`default_nettype wire

/* File: dv/tct_monitor.sv */
`default_nettype none
module tct_monitor (
  input wire logic                       clk,
  input wire logic                       nrst,
  input wire logic [tct_pkg::TCT_AW-1:0] addr,
  input wire logic [31:0]                wdata,
  input wire logic                       wr,
  input wire logic                       rd,
  input wire logic [31:0]                rdata,
  input wire logic [tct_pkg::TCT_N-1:0]  timer_en,
  input wire logic [tct_pkg::TCT_N-1:0]  timer_clk,
  input wire logic [tct_pkg::TCT_N-1:0]  timer_irq
);
  timeunit 1ns;
  timeprecision 100ps;
  import tct_pkg::*;
  logic [3:0] cause_hist;
  logic       clk_prev;
  logic [7:0] since_rise;

  // recent bus accesses, the only legal causes of a falling flag or of a flag rise on a stopped timer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cause_hist <= 4'h0;
    end else begin
      cause_hist <= {cause_hist[2:0], wr | rd};
    end
  end

  // cycles since the counting clock of timer 0 last rose, saturating
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      clk_prev   <= 1'b0;
      since_rise <= 8'hff;
    end else begin
      clk_prev <= timer_clk[0];
      if (timer_clk[0] && !clk_prev) begin
        since_rise <= 8'h00;
      end else if (since_rise != 8'hff) begin
        since_rise <= since_rise + 8'h01;
      end
    end
  end

  default clocking mon_cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence ack_rd;
    rd && (addr == OFF_ACK || addr == OFF_ACK + TIMER_STRIDE || addr == OFF_ACK + 2 * TIMER_STRIDE
           || addr == OFF_ALL_ACK);
  endsequence
  sequence count0_off_rd;
    rd && addr == OFF_COUNT && !timer_en[0] && !$past(timer_en[0]);
  endsequence
  sequence narrow_rd;
    rd && (addr == OFF_ALL_FLAGS || addr == OFF_ALL_RAW || addr == OFF_SETUP);
  endsequence

  strobe_excl_a: assert property (!(wr && rd))
    else $error("write and read strobes together");
  rdata_idle_a: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("read data not zero outside answer cycle");
  ack_zero_a: assert property (ack_rd |=> rdata == 32'h0)
    else $error("ack read returned nonzero");
  count_off_a: assert property (count0_off_rd |=> rdata == 32'h0)
    else $error("disabled count read nonzero");
  resv_bits_a: assert property (narrow_rd |=> rdata[31:3] == 29'h0)
    else $error("reserved bits set in read data");
  en_write_a: assert property ($changed(timer_en[0]) |->
    $past(wr && addr == OFF_SETUP) && $past(wdata[0]) == timer_en[0])
    else $error("enable output changed without setup write");
  irq_hold_a: assert property (|($past(timer_irq) & ~timer_irq) |-> |cause_hist)
    else $error("interrupt dropped without ack or mask");
  irq_rise_a: assert property (|(timer_irq & ~$past(timer_irq) & ~timer_en) |-> |cause_hist)
    else $error("interrupt rose on a stopped timer");
  clk_start_a: assert property ($rose(timer_clk[0]) && !timer_en[0] |->
    since_rise < 8'(4 * TCLK_HALF_CYCLES))
    else $error("counting clock started on a stopped timer");
endmodule
`default_nettype wire

/* File: dv/testbench.sv */
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import tct_pkg::*;
  logic        clk;
  logic        nrst;
  logic [7:0]  cmd_addr;
  logic [31:0] cmd_wdata;
  logic        cmd_wr;
  logic        cmd_rd;
  logic [31:0] cmd_rdata;
  logic [2:0]  timer_irq;
  logic [31:0] r;
  int          n_errors;
  int          n_compared;

  tct_if tct_if_inst ();
  tct_host tct_host_inst (.clk(clk), .nrst(nrst), .bus(tct_if_inst), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata));
  tct_device tct_device_inst (.clk(clk), .nrst(nrst), .bus(tct_if_inst), .timer_irq(timer_irq));
  tct_monitor tct_monitor_inst (.clk(clk), .nrst(nrst), .addr(tct_if_inst.addr),
    .wdata(tct_if_inst.wdata), .wr(tct_if_inst.wr), .rd(tct_if_inst.rd), .rdata(tct_if_inst.rdata),
    .timer_en(tct_if_inst.timer_en), .timer_clk(tct_if_inst.timer_clk), .timer_irq(timer_irq));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic timed_out(input string what);
    n_errors++;
    $display("MISMATCH %s expected done seen timeout", what);
    stop_test();
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cmd_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cmd_addr  <= a;
    cmd_wdata <= d;
    cmd_wr    <= 1'b1;
    @(posedge clk);
    cmd_wr    <= 1'b0;
  endtask

  task automatic cmd_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    cmd_addr <= a;
    cmd_rd   <= 1'b1;
    @(posedge clk);
    cmd_rd   <= 1'b0;
    #1;
    d = cmd_rdata;
  endtask

  // one device access through the host, polled to completion
  task automatic go(input logic [7:0] a, input logic [31:0] d, input logic w, output logic [31:0] res);
    logic [31:0] st;
    st = 32'h1;
    cmd_write(HOFF_TARGET, {24'h0, a});
    cmd_write(HOFF_DATA, d);
    cmd_write(HOFF_GO, {31'h0, w});
    repeat (3) @(posedge clk);
    for (int i = 0; i < 20 && st[0] !== 1'b0; i++) cmd_read(HOFF_STATUS, st);
    if (st[0] !== 1'b0) timed_out("host busy");
    cmd_read(HOFF_RESULT, res);
  endtask

  task automatic dev_wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] res;
    go(a, d, 1'b1, res);
  endtask

  task automatic dev_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] res;
    go(a, 32'h0, 1'b0, res);
    check(what, res, exp);
  endtask

  task automatic wait_irq(input int n);
    for (int i = 0; i < 800 && timer_irq[n] !== 1'b1; i++) @(posedge clk);
    if (timer_irq[n] !== 1'b1) timed_out("irq wait");
  endtask

  initial begin
    nrst = 1'b0;
    cmd_addr = 8'h00;
    cmd_wdata = 32'h0;
    cmd_wr = 1'b0;
    cmd_rd = 1'b0;
    n_errors = 0;
    n_compared = 0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    for (int n = 0; n < 3; n++) begin
      dev_chk("reload rst", 8'(n) * TIMER_STRIDE + OFF_RELOAD, 32'h0);
      dev_chk("count rst", 8'(n) * TIMER_STRIDE + OFF_COUNT, 32'h0);
      dev_wr(8'(n) * TIMER_STRIDE + OFF_RELOAD, 32'ha5c3_0f00 ^ 32'(n));
      dev_wr(8'(n) * TIMER_STRIDE + OFF_SETUP, 32'hffff_fff8);
      dev_chk("reload rw", 8'(n) * TIMER_STRIDE + OFF_RELOAD, 32'ha5c3_0f00 ^ 32'(n));
      dev_chk("setup resv", 8'(n) * TIMER_STRIDE + OFF_SETUP, 32'h0);
      dev_chk("flag rst", 8'(n) * TIMER_STRIDE + OFF_FLAG, 32'h0);
    end
    dev_wr(8'h3c, 32'hffff_ffff);
    dev_chk("unmapped", 8'h3c, 32'h0);
    dev_chk("raw rst", OFF_ALL_RAW, 32'h0);
    $display("test registers done");

    dev_wr(OFF_SETUP, 32'h2);
    dev_wr(OFF_RELOAD, 32'h20);
    dev_wr(OFF_SETUP, 32'h3);
    check("enable out", {29'h0, tct_if_inst.timer_en}, 32'h1);
    cmd_read(HOFF_STATUS, r);
    check("host status", r, 32'h4);
    cmd_write(HOFF_CLK_GATE, 32'h6);
    cmd_read(HOFF_CLK_GATE, r);
    check("gate readback", r, 32'h6);
    wait_irq(0);
    dev_chk("raw one", OFF_ALL_RAW, 32'h1);
    dev_chk("masked one", OFF_ALL_FLAGS, 32'h1);
    dev_chk("flag one", OFF_FLAG, 32'h1);
    go(OFF_COUNT, 32'h0, 1'b0, r);
    check("count range", {31'h0, r <= 32'h20}, 32'h1);
    dev_chk("ack one", OFF_ACK, 32'h0);
    check("irq acked", {29'h0, timer_irq}, 32'h0);
    wait_irq(0);
    dev_wr(OFF_SETUP, 32'h2);
    cmd_write(HOFF_CLK_GATE, 32'h7);
    check("enable off", {29'h0, tct_if_inst.timer_en}, 32'h0);
    dev_chk("count off", OFF_COUNT, 32'h0);
    check("irq held", {29'h0, timer_irq}, 32'h1);
    dev_chk("ack all", OFF_ALL_ACK, 32'h0);
    $display("test user mode done");

    dev_wr(TIMER_STRIDE + OFF_RELOAD, 32'h2);
    dev_wr(TIMER_STRIDE + OFF_SETUP, 32'h1);
    dev_wr(8'(2 * TIMER_STRIDE) + OFF_SETUP, 32'h6);
    dev_wr(8'(2 * TIMER_STRIDE) + OFF_RELOAD, 32'h3);
    dev_wr(8'(2 * TIMER_STRIDE) + OFF_SETUP, 32'h7);
    cmd_write(HOFF_CLK_GATE, 32'h1);
    wait_irq(1);
    repeat (16) @(posedge clk);
    dev_chk("raw two", OFF_ALL_RAW, 32'h6);
    dev_chk("masked two", OFF_ALL_FLAGS, 32'h2);
    check("irq masked", {29'h0, timer_irq}, 32'h2);
    go(TIMER_STRIDE + OFF_COUNT, 32'h0, 1'b0, r);
    check("free reload", {31'h0, r > 32'hffff_0000}, 32'h1);
    dev_wr(TIMER_STRIDE + OFF_SETUP, 32'h5);
    check("irq mask", {29'h0, timer_irq}, 32'h0);
    dev_wr(TIMER_STRIDE + OFF_SETUP, 32'h0);
    dev_wr(8'(2 * TIMER_STRIDE) + OFF_SETUP, 32'h6);
    cmd_write(HOFF_CLK_GATE, 32'h7);
    check("irq unmask", {29'h0, timer_irq}, 32'h2);
    dev_chk("ack all two", OFF_ALL_ACK, 32'h0);
    dev_chk("raw clear", OFF_ALL_RAW, 32'h0);
    check("irq clear", {29'h0, timer_irq}, 32'h0);
    $display("test free mode done");

    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    dev_chk("reload rerst", OFF_RELOAD, 32'h0);
    $display("test second reset done");
    stop_test();
  end
endmodule
`default_nettype wire
